// file: verilog/amd_datapath.sv
// Purpose: 16-bit alu, 17x17 multiplier, iterative divider and 40-bit dsp engine
// Assumes: decoder presents one operation per cycle with operands already read
// Notes: all results leave one edge after acceptance, divide after 17 edges
`timescale 1ns/10ps
// Operation
// (RULE1) 16-bit add, subtract, shift and logic
// (RULE2) arithmetic is two's complement
// (RULE3) update carry, zero, negative, overflow, half-carry
// (RULE4) subtract: carry means no borrow
// (RULE5) byte or word width per instruction
// (RULE6) operand from register or memory, both destinations
// (RULE7) one 17x17 array, sign-extended operands
// (RULE8) signed, unsigned, mixed, literal and byte multiplies
// (RULE9) signed or unsigned 32/16 and 16/16 divide
// (RULE10) quotient to register zero, remainder to one
// (RULE11) dividend from aligned pair, high word odd
// (RULE12) one quotient bit per cycle, equal time
// (RULE13) 40-bit shifter and adder into two accumulators
// (RULE14) accumulator add, subtract and negate
// (RULE15) fractional or integer, signed/unsigned/mixed multiply
// (RULE16) conventional or convergent rounding select
// (RULE17) clamp enables for a, b and stores
// (RULE18) clamp range select for accumulators
// (RULE19) dsp op set with other-accumulator write-back
// (RULE20) byte mode keeps destination upper byte
module amd_datapath
    import amd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // decoded operation
    input wire logic op_valid_i,
    input wire amd_op_t op_i,
    input wire logic byte_i,
    input wire logic src_mem_i,
    input wire logic dst_mem_i,
    input wire logic [15:0] opa_w_i,
    input wire logic [15:0] opa_m_i,
    input wire logic [15:0] opb_i,
    input wire logic [4:0] lit_i,
    input wire logic div_long_i,
    input wire logic [15:0] dvd_hi_i,
    input wire logic acc_sel_i,
    input wire logic [15:0] mx_i,
    input wire logic [15:0] my_i,
    // results
    output logic busy_o,
    output logic wb_valid_o,
    output logic wb_mem_o,
    output logic [15:0] wb_data_o,
    output logic [15:0] wb_hi_o,
    output logic div_done_o,
    output logic [15:0] quotient_work_reg_o,
    output logic [15:0] remainder_work_reg_o,
    output logic acc_wb_valid_o,
    output logic [15:0] acc_wb_data_o,
    output logic [39:0] accumulator_a_o,
    output logic [39:0] accumulator_b_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    logic [7:0] core_control_reg_r;
    logic [4:0] status_flags_reg_r;
    logic [39:0] accumulator_a_r;
    logic [39:0] accumulator_b_r;
    amd_dv_t dv_state_r;
    logic [3:0] dv_cnt_r;
    logic [15:0] dv_rem_r;
    logic [15:0] dv_quo_r;
    logic [15:0] dv_dsr_r;
    logic dv_qneg_r;
    logic dv_rneg_r;
    logic dv_sgn_r;
    logic [31:0] dv_chk_r;
    logic [31:0] prdata_r;
    logic go;
    logic is_alu;
    logic is_mul;
    logic is_div;
    logic is_dsp;
    logic int_mode;
    logic rnd_conv;
    logic sat_a;
    logic sat_b;
    logic sat_dw;
    logic sat_wide;
    logic [1:0] sign_mode_select;
    logic [15:0] opa;

    function automatic logic [39:0] clamp40(input logic [40:0] s, input logic en, input logic wide);
        logic [39:0] r;
        r = s[39:0];
        if (en && !wide && (s[40:31] != {10{s[40]}}))
            r = s[40] ? AMD_SAT31_NEG : AMD_SAT31_POS;
        else if (en && wide && (s[40] != s[39]))
            r = s[40] ? AMD_SAT39_NEG : AMD_SAT39_POS;
        return r;
    endfunction

    function automatic logic [15:0] store16(input logic [39:0] acc, input logic conv, input logic sat);
        logic [39:0] r;
        r = acc + AMD_ROUND_HALF;
        // a tie with an even upper word is truncated, not rounded up
        if (conv && (acc[15:0] == AMD_ROUND_TIE) && !acc[16])
            r = acc;
        if (sat && (r[39:31] != {9{r[39]}}))
            return r[39] ? AMD_ST_NEG : AMD_ST_POS;
        return r[31:16];
    endfunction

    // a divide in flight refuses new work; the decoder stalls on busy_o
    assign busy_o = (dv_state_r == DV_RUN);
    assign go = op_valid_i && !busy_o;
    assign is_alu = (op_i <= OP_ASR);
    assign is_mul = (op_i >= OP_MUL_SS) && (op_i <= OP_MUL_BB);
    assign is_div = (op_i == OP_DIV_S) || (op_i == OP_DIV_U);
    assign is_dsp = (op_i >= OP_AADD);
    assign int_mode = core_control_reg_r[AMD_CB_INT];
    assign sign_mode_select = core_control_reg_r[AMD_CB_SGN +: 2];
    assign rnd_conv = core_control_reg_r[AMD_CB_ROUND];
    assign sat_a = core_control_reg_r[AMD_CB_CLA];
    assign sat_b = core_control_reg_r[AMD_CB_CLB];
    assign sat_dw = core_control_reg_r[AMD_CB_CLST];
    assign sat_wide = core_control_reg_r[AMD_CB_WIDE];
    assign opa = src_mem_i ? opa_m_i : opa_w_i; // see (RULE6)

    // apb: zero wait states, unmapped addresses answer with pslverr
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && (paddr_i != AMD_OFS_CTRL) && (paddr_i != AMD_OFS_STAT);
    assign prdata_o = prdata_r;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            core_control_reg_r <= AMD_CTRL_RST;
        else if (psel_i && penable_i && pwrite_i && (paddr_i == AMD_OFS_CTRL))
            core_control_reg_r <= pwdata_i[7:0]; // see (RULE15) (RULE16) (RULE17) (RULE18)
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            prdata_r <= 32'h00000000;
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            if (paddr_i == AMD_OFS_CTRL)
                prdata_r <= {24'h000000, core_control_reg_r};
            else if (paddr_i == AMD_OFS_STAT)
                prdata_r <= {23'h000000, busy_o, 3'h0, status_flags_reg_r};
            else
                prdata_r <= 32'h00000000;
        end
    end

    // byte operands are aligned to the top so carry and overflow fall out of the word path
    logic [15:0] aw;
    logic [15:0] bw;
    logic [15:0] bx;
    logic [15:0] r16;
    logic [15:0] cx;
    logic [16:0] s17;
    logic [4:0] fl_nxt;
    logic [15:0] alu_res;

    always_comb
    begin
        aw = byte_i ? {opa[7:0], 8'h00} : opa; // see (RULE5)
        bw = byte_i ? {opb_i[7:0], 8'h00} : opb_i;
        bx = (op_i == OP_SUB) ? ~bw : bw;
        s17 = {1'b0, aw} + {1'b0, bx} + {16'h0000, op_i == OP_SUB}; // see (RULE2)
        cx = s17[15:0] ^ aw ^ bx;
        r16 = s17[15:0];
        fl_nxt = status_flags_reg_r;
        case (op_i)
            OP_ADD, OP_SUB:
            begin
                fl_nxt[AMD_SB_C] = s17[16]; // see (RULE4)
                fl_nxt[AMD_SB_H] = byte_i ? cx[12] : cx[8];
                fl_nxt[AMD_SB_V] = (aw[15] == bx[15]) && (r16[15] != aw[15]);
            end
            OP_AND: r16 = aw & bw; // see (RULE1)
            OP_IOR: r16 = aw | bw;
            OP_XOR: r16 = aw ^ bw;
            OP_SHL:
            begin
                r16 = {aw[14:0], 1'b0};
                fl_nxt[AMD_SB_C] = aw[15];
                fl_nxt[AMD_SB_V] = aw[15] ^ aw[14];
            end
            OP_LSR, OP_ASR:
            begin
                r16 = {(op_i == OP_ASR) && aw[15], aw[15:1]};
                fl_nxt[AMD_SB_C] = byte_i ? aw[8] : aw[0];
            end
            default: ;
        endcase
        fl_nxt[AMD_SB_N] = r16[15]; // see (RULE3)
        fl_nxt[AMD_SB_Z] = byte_i ? (r16[15:8] == 8'h00) : (r16 == 16'h0000);
        alu_res = byte_i ? {opa[15:8], r16[15:8]} : r16; // see (RULE20)
    end

    // one 17x17 signed array serves integer and dsp multiplies
    logic sa;
    logic sb;
    logic [15:0] ma16;
    logic [15:0] mb16;
    logic [16:0] ma;
    logic [16:0] mb;
    logic [16:0] dxy;
    logic signed [33:0] prod;
    logic [39:0] p40;

    always_comb
    begin
        sa = 1'b1;
        sb = 1'b1;
        ma16 = opa;
        mb16 = opb_i;
        case (op_i)
            OP_MUL_SS: ;
            OP_MUL_UU: {sa, sb} = 2'h0; // see (RULE8)
            OP_MUL_SU: sb = 1'b0;
            OP_MUL_US: sa = 1'b0;
            OP_MUL_SL:
            begin
                sb = 1'b0;
                mb16 = {11'h000, lit_i};
            end
            OP_MUL_UL:
            begin
                {sa, sb} = 2'h0;
                mb16 = {11'h000, lit_i};
            end
            OP_MUL_BB:
            begin
                {sa, sb} = 2'h0;
                ma16 = {8'h00, opa[7:0]};
                mb16 = {8'h00, opb_i[7:0]};
            end
            default:
            begin
                ma16 = mx_i;
                mb16 = ((op_i == OP_SQACC) || (op_i == OP_SQR)) ? mx_i : my_i;
                sa = (sign_mode_select != AMD_SGN_UU); // see (RULE15)
                sb = (sign_mode_select == AMD_SGN_SS);
            end
        endcase
        ma = {sa & ma16[15], ma16}; // see (RULE7)
        mb = {sb & mb16[15], mb16};
        dxy = {mx_i[15], mx_i} - {my_i[15], my_i};
        if ((op_i == OP_DSQ) || (op_i == OP_DSQACC))
        begin
            ma = dxy;
            mb = dxy;
        end
        prod = $signed(ma) * $signed(mb);
        p40 = int_mode ? {{6{prod[33]}}, prod} : {{5{prod[33]}}, prod, 1'b0};
    end

    // dsp: 41-bit sum keeps the overflow bit for the clamp
    logic [39:0] tgt;
    logic [39:0] oth;
    logic [40:0] sum41;
    logic [39:0] acc_nxt;
    logic acc_upd;
    logic acc_wbo;

    always_comb
    begin
        tgt = acc_sel_i ? accumulator_b_r : accumulator_a_r;
        oth = acc_sel_i ? accumulator_a_r : accumulator_b_r;
        acc_upd = 1'b1;
        acc_wbo = 1'b0;
        case (op_i)
            OP_CLR:
            begin
                sum41 = 41'h0;
                acc_wbo = 1'b1; // see (RULE19)
            end
            OP_DSQ, OP_MULT, OP_SQR: sum41 = {p40[39], p40};
            OP_DSQACC, OP_SQACC: sum41 = {tgt[39], tgt} + {p40[39], p40};
            OP_MULACC:
            begin
                sum41 = {tgt[39], tgt} + {p40[39], p40};
                acc_wbo = 1'b1;
            end
            OP_MULSUB:
            begin
                sum41 = {tgt[39], tgt} - {p40[39], p40};
                acc_wbo = 1'b1;
            end
            OP_NMULT: sum41 = 41'h0 - {p40[39], p40};
            OP_AADD: sum41 = {tgt[39], tgt} + {oth[39], oth}; // see (RULE14)
            OP_ASUB: sum41 = {tgt[39], tgt} - {oth[39], oth};
            OP_ANEG: sum41 = 41'h0 - {tgt[39], tgt};
            OP_STORE:
            begin
                sum41 = {tgt[39], tgt};
                acc_upd = 1'b0;
                acc_wbo = 1'b1;
            end
            default:
            begin
                sum41 = 41'h0;
                acc_upd = 1'b0;
            end
        endcase
        acc_nxt = clamp40(sum41, acc_sel_i ? sat_b : sat_a, sat_wide); // see (RULE13) (RULE17) (RULE18)
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            status_flags_reg_r <= AMD_STAT_RST;
        else if (go && is_alu)
            status_flags_reg_r <= fl_nxt; // see (RULE3)
        else if (psel_i && penable_i && pwrite_i && (paddr_i == AMD_OFS_STAT))
            status_flags_reg_r <= pwdata_i[4:0];
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wb_valid_o <= 1'b0;
            wb_mem_o <= 1'b0;
            wb_data_o <= 16'h0000;
            wb_hi_o <= 16'h0000;
        end
        else
        begin
            wb_valid_o <= go && (is_alu || is_mul);
            if (go && (is_alu || is_mul))
            begin
                wb_mem_o <= dst_mem_i; // see (RULE6)
                wb_data_o <= is_alu ? alu_res : prod[15:0];
                wb_hi_o <= is_alu ? 16'h0000 : prod[31:16];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            accumulator_a_r <= 40'h0;
            accumulator_b_r <= 40'h0;
        end
        else if (go && is_dsp && acc_upd && acc_sel_i)
            accumulator_b_r <= acc_nxt;
        else if (go && is_dsp && acc_upd)
            accumulator_a_r <= acc_nxt;
    end
    assign accumulator_a_o = accumulator_a_r;
    assign accumulator_b_o = accumulator_b_r;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_wb_valid_o <= 1'b0;
            acc_wb_data_o <= 16'h0000;
        end
        else
        begin
            acc_wb_valid_o <= go && is_dsp && acc_wbo;
            if (go && is_dsp && acc_wbo)
                acc_wb_data_o <= store16(oth, rnd_conv, sat_dw); // see (RULE16) (RULE19)
        end
    end

    // divider: restoring, on magnitudes, signs applied at the end
    logic dsg;
    logic dnd;
    logic dns;
    logic [31:0] dvd32;
    logic [31:0] dmag;
    logic [15:0] smag;
    logic [17:0] trial;
    logic [15:0] rem_n;
    logic [15:0] quo_n;

    always_comb
    begin
        dsg = (op_i == OP_DIV_S);
        dvd32 = div_long_i ? {dvd_hi_i, opa} : {{16{dsg & opa[15]}}, opa}; // see (RULE11)
        dnd = dsg & dvd32[31];
        dns = dsg & opb_i[15];
        dmag = dnd ? -dvd32 : dvd32; // see (RULE9)
        smag = dns ? -opb_i : opb_i;
        trial = {1'b0, dv_rem_r, dv_quo_r[15]} - {2'h0, dv_dsr_r};
        rem_n = trial[17] ? {dv_rem_r[14:0], dv_quo_r[15]} : trial[15:0];
        quo_n = {dv_quo_r[14:0], !trial[17]};
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dv_state_r <= DV_IDLE;
            dv_cnt_r <= 4'h0;
            dv_rem_r <= 16'h0000;
            dv_quo_r <= 16'h0000;
            dv_dsr_r <= 16'h0000;
            dv_qneg_r <= 1'b0;
            dv_rneg_r <= 1'b0;
            dv_sgn_r <= 1'b0;
            dv_chk_r <= 32'h00000000;
            div_done_o <= 1'b0;
            quotient_work_reg_o <= 16'h0000;
            remainder_work_reg_o <= 16'h0000;
        end
        else
        begin
            div_done_o <= 1'b0;
            unique case (dv_state_r)
                DV_IDLE:
                    if (go && is_div)
                    begin
                        dv_state_r <= DV_RUN;
                        dv_cnt_r <= 4'h0;
                        dv_rem_r <= dmag[31:16];
                        dv_quo_r <= dmag[15:0];
                        dv_dsr_r <= smag;
                        dv_qneg_r <= dnd ^ dns;
                        dv_rneg_r <= dnd;
                        dv_sgn_r <= dsg;
                        dv_chk_r <= dvd32;
                    end
                DV_RUN:
                begin
                    dv_rem_r <= rem_n; // see (RULE12)
                    dv_quo_r <= quo_n;
                    dv_cnt_r <= dv_cnt_r + 4'h1;
                    if (dv_cnt_r == AMD_DIV_LAST)
                    begin
                        dv_state_r <= DV_IDLE;
                        div_done_o <= 1'b1;
                        quotient_work_reg_o <= dv_qneg_r ? -quo_n : quo_n; // see (RULE10)
                        remainder_work_reg_o <= dv_rneg_r ? -rem_n : rem_n;
                    end
                end
            endcase
        end
    end

    alu_add_a: assert property (go && op_i == OP_ADD && !byte_i |=> // see (RULE1)
        wb_valid_o && wb_data_o == $past(opa) + $past(opb_i)) else $error("word add result wrong");
    sub_borrow_a: assert property (go && op_i == OP_SUB && !byte_i |=> // see (RULE4)
        status_flags_reg_r[AMD_SB_C] == ($past(opa) >= $past(opb_i))) else $error("borrow flag wrong");
    zero_flag_a: assert property (go && op_i == OP_XOR && !byte_i |=> // see (RULE3)
        status_flags_reg_r[AMD_SB_Z] == ($past(opa) == $past(opb_i))) else $error("zero flag wrong");
    add_ovf_a: assert property (go && op_i == OP_ADD && !byte_i |=> // see (RULE2)
        status_flags_reg_r[AMD_SB_V] == ($past(opa[15]) == $past(opb_i[15]) && wb_data_o[15] != $past(opa[15])))
        else $error("overflow flag wrong");
    byte_keep_a: assert property (go && byte_i && op_i == OP_ADD |=> // see (RULE20)
        wb_data_o == {$past(opa[15:8]), 8'($past(opa[7:0]) + $past(opb_i[7:0]))}) else $error("byte add wrong");
    mul_uu_a: assert property (go && op_i == OP_MUL_UU |=> // see (RULE8)
        {wb_hi_o, wb_data_o} == $past(opa) * $past(opb_i)) else $error("unsigned product wrong");
    mul_ss_a: assert property (go && op_i == OP_MUL_SS |=> // see (RULE7)
        $signed({wb_hi_o, wb_data_o}) == $signed($past(opa)) * $signed($past(opb_i))) else $error("signed product wrong");
    div_time_a: assert property (go && is_div |-> ##17 div_done_o) else $error("divide latency wrong"); // see (RULE12)
    div_value_a: assert property (div_done_o && !dv_sgn_r && dv_chk_r[31:16] < dv_dsr_r |-> // see (RULE10)
        {16'h0000, quotient_work_reg_o} * {16'h0000, dv_dsr_r} + {16'h0000, remainder_work_reg_o} == dv_chk_r)
        else $error("divide result wrong");
    acc_clear_a: assert property (go && op_i == OP_CLR && !acc_sel_i |=> // see (RULE19)
        accumulator_a_r == 40'h0 && acc_wb_valid_o) else $error("clear wrong");
    acc_neg_a: assert property (go && op_i == OP_ANEG && !acc_sel_i && !sat_a |=> // see (RULE14)
        accumulator_a_r == -$past(accumulator_a_r)) else $error("negate wrong");
    acc_clamp_a: assert property (go && op_i == OP_MULACC && !acc_sel_i && sat_a && !sat_wide |=> // see (RULE17)
        accumulator_a_r[39:31] == {9{accumulator_a_r[39]}}) else $error("clamp range wrong");
    round_tie_a: assert property (go && op_i == OP_STORE && !acc_sel_i && rnd_conv && !sat_dw // see (RULE16)
        && accumulator_b_r[16:0] == 17'h08000 |=> acc_wb_data_o == $past(accumulator_b_r[31:16]))
        else $error("convergent tie wrong");
    frac_mul_a: assert property (go && op_i == OP_MULT && !acc_sel_i && !int_mode && !sat_a // see (RULE15)
        && sign_mode_select == AMD_SGN_SS |=> $signed(accumulator_a_r) == 2 * $signed($past(mx_i)) * $signed($past(my_i)))
        else $error("fractional product wrong");
    div_run_c: cover property (go && is_div ##17 div_done_o);
    mulacc_run_c: cover property (go && op_i == OP_MULACC ##1 acc_wb_valid_o);
    byte_op_c: cover property (go && byte_i && op_i == OP_SUB);
endmodule

// file: verilog/amd_pkg.sv
// Purpose: constants and types of the integer and dsp arithmetic datapath
// Assumes: one core clock, registers reached over apb
// Notes: register offsets are byte addresses of aligned words
package amd_pkg;
    // apb register map
    localparam logic [7:0] AMD_OFS_CTRL = 8'h00;
    localparam logic [7:0] AMD_OFS_STAT = 8'h04;

    // core_control_reg field positions
    localparam int AMD_CB_INT = 0;
    localparam int AMD_CB_SGN = 1;
    localparam int AMD_CB_ROUND = 3;
    localparam int AMD_CB_CLA = 4;
    localparam int AMD_CB_CLB = 5;
    localparam int AMD_CB_CLST = 6;
    localparam int AMD_CB_WIDE = 7;
    localparam logic [7:0] AMD_CTRL_RST = 8'h00;

    // status_flags_reg field positions
    localparam int AMD_SB_C = 0;
    localparam int AMD_SB_Z = 1;
    localparam int AMD_SB_N = 2;
    localparam int AMD_SB_V = 3;
    localparam int AMD_SB_H = 4;
    localparam int AMD_SB_BUSY = 8;
    localparam logic [4:0] AMD_STAT_RST = 5'h00;

    // sign_mode_select codes
    localparam logic [1:0] AMD_SGN_SS = 2'h0;
    localparam logic [1:0] AMD_SGN_UU = 2'h1;

    // divider: one quotient bit per cycle over the 16-bit divisor
    localparam logic [3:0] AMD_DIV_LAST = 4'hf;

    // rounding and clamp limits
    localparam logic [39:0] AMD_ROUND_HALF = 40'h0000008000;
    localparam logic [15:0] AMD_ROUND_TIE = 16'h8000;
    localparam logic [39:0] AMD_SAT31_POS = 40'h007fffffff;
    localparam logic [39:0] AMD_SAT31_NEG = 40'hff80000000;
    localparam logic [39:0] AMD_SAT39_POS = 40'h7fffffffff;
    localparam logic [39:0] AMD_SAT39_NEG = 40'h8000000000;
    localparam logic [15:0] AMD_ST_POS = 16'h7fff;
    localparam logic [15:0] AMD_ST_NEG = 16'h8000;

    typedef enum logic [4:0] {
        OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_IOR = 5'h03,
        OP_XOR = 5'h04, OP_SHL = 5'h05, OP_LSR = 5'h06, OP_ASR = 5'h07,
        OP_MUL_SS = 5'h08, OP_MUL_UU = 5'h09, OP_MUL_SU = 5'h0a, OP_MUL_US = 5'h0b,
        OP_MUL_SL = 5'h0c, OP_MUL_UL = 5'h0d, OP_MUL_BB = 5'h0e,
        OP_DIV_S = 5'h0f, OP_DIV_U = 5'h10,
        OP_AADD = 5'h11, OP_ASUB = 5'h12, OP_ANEG = 5'h13, OP_CLR = 5'h14,
        OP_DSQ = 5'h15, OP_DSQACC = 5'h16, OP_MULACC = 5'h17, OP_SQACC = 5'h18,
        OP_STORE = 5'h19, OP_MULT = 5'h1a, OP_SQR = 5'h1b, OP_NMULT = 5'h1c,
        OP_MULSUB = 5'h1d
    } amd_op_t;

    typedef enum logic [0:0] {
        DV_IDLE = 1'b0,
        DV_RUN = 1'b1
    } amd_dv_t;
endpackage

// file: verification/amd_regfile_model.sv
// Purpose: working register pair that takes divide results
// Assumes: results are valid in the cycle of div_done
// Notes: only the two fixed divide targets are modelled
`timescale 1ns/10ps
module amd_regfile_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // divide result
    input wire logic div_done_i,
    input wire logic [15:0] quot_i,
    input wire logic [15:0] rem_i,
    // working registers zero and one
    output logic [15:0] quotient_work_reg_o,
    output logic [15:0] remainder_work_reg_o
);
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            quotient_work_reg_o <= 16'h0000;
            remainder_work_reg_o <= 16'h0000;
        end
        else if (div_done_i)
        begin
            quotient_work_reg_o <= quot_i;
            remainder_work_reg_o <= rem_i;
        end
    end
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench of the arithmetic datapath
// Assumes: apb answers at once, ops answer one edge later
// Notes: assertions live in the design files
`timescale 1ns/10ps
module testbench;
    import amd_pkg::*;
    logic mclk_i = 0, resetn_i = 0, psel = 0, pen = 0, pwr = 0, opv = 0, byt = 0, smem = 0, dmem = 0;
    logic dlong = 0, asel = 0, pready, pslverr, busy, wbv, wbm, dd, accv, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] opa = 16'h0, opam = 16'h0, opb = 16'h0, dhi = 16'h0, mx = 16'h0, my = 16'h0;
    logic [15:0] wbd, wbh, q, r, accd, quo_w, rem_w;
    logic [4:0] lit = 5'h00;
    logic [39:0] acc_a, acc_b;
    amd_op_t opc = OP_ADD;
    int fails = 0, total_checks = 0, n;
    amd_datapath amd_datapath_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .op_valid_i(opv), .op_i(opc), .byte_i(byt), .src_mem_i(smem), .dst_mem_i(dmem),
        .opa_w_i(opa), .opa_m_i(opam), .opb_i(opb), .lit_i(lit), .div_long_i(dlong), .dvd_hi_i(dhi),
        .acc_sel_i(asel), .mx_i(mx), .my_i(my), .busy_o(busy), .wb_valid_o(wbv), .wb_mem_o(wbm),
        .wb_data_o(wbd), .wb_hi_o(wbh), .div_done_o(dd), .quotient_work_reg_o(q), .remainder_work_reg_o(r),
        .acc_wb_valid_o(accv), .acc_wb_data_o(accd), .accumulator_a_o(acc_a), .accumulator_b_o(acc_b));
    amd_regfile_model amd_regfile_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .div_done_i(dd),
        .quot_i(q), .rem_i(r), .quotient_work_reg_o(quo_w), .remainder_work_reg_o(rem_w));
    initial forever #50 mclk_i = ~mclk_i;
    task chk(input logic [39:0] s, input logic [39:0] e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        pen <= 1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    // results land on the taking edge; they are read at the next edge, before it updates them
    task op(input amd_op_t o, input logic [15:0] a, input logic [15:0] b);
        @(posedge mclk_i);
        opv <= 1;
        opc <= o;
        opa <= a;
        opb <= b;
        @(posedge mclk_i);
        opv <= 0;
        @(posedge mclk_i);
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #2000000;
        fails++;
        results;
    end
    initial
    begin
        repeat (12) @(posedge mclk_i);
        resetn_i <= 1;
        apb(1, AMD_OFS_CTRL, 32'ha5);
        apb(0, AMD_OFS_CTRL, 0);
        chk(rd, 32'ha5);
        apb(0, 8'h08, 0);
        chk({err, rd}, 33'h100000000);
        $display("test registers done");
        op(OP_ADD, 16'h7fff, 16'h0001);
        chk({wbv, wbd}, 17'h18000);
        apb(0, AMD_OFS_STAT, 0);
        chk(rd, 32'h1c);
        smem <= 1;
        dmem <= 1;
        opam <= 16'h0005;
        op(OP_SUB, 16'h1234, 16'h0005);
        chk({wbm, wbd}, 17'h10000);
        apb(0, AMD_OFS_STAT, 0);
        chk(rd, 32'h13);
        smem <= 0;
        dmem <= 0;
        byt <= 1;
        op(OP_ADD, 16'h12ff, 16'h0001);
        chk(wbd, 16'h1200);
        apb(0, AMD_OFS_STAT, 0);
        chk(rd, 32'h13);
        byt <= 0;
        op(OP_SHL, 16'hc001, 16'h0000);
        chk({wbv, wbd}, 17'h18002);
        op(OP_XOR, 16'h5a5a, 16'h5a5a);
        chk({wbv, wbd}, 17'h10000);
        $display("test alu done");
        op(OP_MUL_UU, 16'hffff, 16'hffff);
        chk({wbh, wbd}, 32'hfffe0001);
        op(OP_MUL_SS, 16'hffff, 16'hffff);
        chk({wbh, wbd}, 32'h00000001);
        op(OP_MUL_SU, 16'hffff, 16'h0002);
        chk({wbh, wbd}, 32'hfffffffe);
        op(OP_MUL_BB, 16'h12ff, 16'h34ff);
        chk({wbh, wbd}, 32'h0000fe01);
        lit <= 5'h1f;
        op(OP_MUL_UL, 16'h1000, 16'h0000);
        chk({wbh, wbd}, 32'h0001f000);
        $display("test multiply done");
        dlong <= 1;
        dhi <= 16'h0001;
        op(OP_DIV_U, 16'h0000, 16'h0003);
        n = 1;
        while (dd !== 1'b1 && n < 40)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk(n, 17);
        @(posedge mclk_i);
        chk({quo_w, rem_w}, 32'h55550001);
        dlong <= 0;
        op(OP_DIV_S, 16'hfff9, 16'h0002);
        chk(busy, 1'b1);
        repeat (16) @(posedge mclk_i);
        chk({busy, dd, q, r}, 34'h1fffdffff);
        @(posedge mclk_i);
        chk({quo_w, rem_w}, 32'hfffdffff);
        $display("test divide done");
        apb(1, AMD_OFS_CTRL, 32'h01);
        mx <= 16'h0003;
        my <= 16'h0004;
        op(OP_MULT, 16'h0, 16'h0);
        chk(acc_a, 40'h000000000c);
        asel <= 1;
        op(OP_NMULT, 16'h0, 16'h0);
        chk(acc_b, 40'hfffffffff4);
        asel <= 0;
        op(OP_MULACC, 16'h0, 16'h0);
        chk({accv, accd}, 17'h10000);
        chk(acc_a, 40'h0000000018);
        op(OP_CLR, 16'h0, 16'h0);
        chk(acc_a, 40'h0);
        apb(1, AMD_OFS_CTRL, 32'h08);
        op(OP_MULT, 16'h0, 16'h0);
        chk(acc_a, 40'h0000000018);
        op(OP_ANEG, 16'h0, 16'h0);
        chk(acc_a, 40'hffffffffe8);
        asel <= 1;
        op(OP_AADD, 16'h0, 16'h0);
        chk(acc_b, 40'hffffffffdc);
        apb(1, AMD_OFS_CTRL, 32'h09);
        mx <= 16'h0100;
        my <= 16'h0080;
        op(OP_MULT, 16'h0, 16'h0);
        asel <= 0;
        op(OP_STORE, 16'h0, 16'h0);
        chk({accv, accd}, 17'h10000);
        apb(1, AMD_OFS_CTRL, 32'h01);
        op(OP_STORE, 16'h0, 16'h0);
        chk({accv, accd}, 17'h10001);
        apb(1, AMD_OFS_CTRL, 32'h10);
        mx <= 16'h8000;
        my <= 16'h8000;
        op(OP_MULACC, 16'h0, 16'h0);
        op(OP_MULACC, 16'h0, 16'h0);
        chk(acc_a, 40'h007fffffff);
        $display("test dsp done");
        results;
    end
endmodule
